// *** design/flash_cmd_pkg.sv ***
package flash_cmd_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FREAD = 8'h0b;
    localparam logic [7:0] OP_DREAD = 8'h3b;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_PP_ALT = 8'hf2;
    localparam logic [7:0] OP_SE = 8'h20;
    localparam logic [7:0] OP_BE32 = 8'h52;
    localparam logic [7:0] OP_BE64 = 8'hd8;
    localparam logic [7:0] OP_CE = 8'hc7;
    localparam logic [7:0] OP_CE_ALT = 8'h60;
    localparam logic [7:0] OP_DPD = 8'hb9;
    localparam logic [7:0] OP_RDP_ID = 8'hab;
    localparam logic [7:0] OP_MFID = 8'h90;
    localparam logic [7:0] OP_JEDEC = 8'h9f;
    // status bit positions
    localparam int S_BUSY = 0;
    localparam int S_WRITE_EN = 1;
    localparam int S_LOCK = 7;
    // byte counts at which a frame ends or output starts
    localparam logic [3:0] N_OP = 4'h1;
    localparam logic [3:0] N_WSR_ONE = 4'h2;
    localparam logic [3:0] N_WSR_TWO = 4'h3;
    localparam logic [3:0] N_ADDR_END = 4'h4;
    localparam logic [3:0] N_FAST_START = 4'h5;
    localparam logic [3:0] N_NONE = 4'h0;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    // identification defaults, values arbitrary
    localparam logic [7:0] MAKER_CODE_DEF = 8'ha5;
    localparam logic [7:0] PART_HIGH_DEF = 8'h3c;
    localparam logic [7:0] PART_LOW_DEF = 8'h17;
    localparam logic [7:0] LEGACY_PART_DEF = 8'h16;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned STATUS_WRITE_TIME_NS = 5000000;
    localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {ST_WAIT, ST_OPCODE, ST_IN, ST_OUT, ST_IGNORE} dec_state_t;
    typedef enum logic [2:0] {
        ARR_NONE, ARR_PROGRAM, ARR_SECTOR, ARR_BLOCK32, ARR_BLOCK64, ARR_CHIP
    } array_op_t;

    function automatic logic [3:0] out_start(input logic [7:0] op);
        case (op)
            OP_READ_STATUS, OP_JEDEC: out_start = N_OP;
            OP_READ, OP_RDP_ID, OP_MFID: out_start = N_ADDR_END;
            OP_FREAD, OP_DREAD: out_start = N_FAST_START;
            default: out_start = N_NONE;
        endcase
    endfunction

    function automatic array_op_t arr_kind(input logic [7:0] op);
        case (op)
            OP_PP, OP_PP_ALT: arr_kind = ARR_PROGRAM;
            OP_SE: arr_kind = ARR_SECTOR;
            OP_BE32: arr_kind = ARR_BLOCK32;
            OP_BE64: arr_kind = ARR_BLOCK64;
            OP_CE, OP_CE_ALT: arr_kind = ARR_CHIP;
            default: arr_kind = ARR_NONE;
        endcase
    endfunction

    function automatic logic frame_ok(input logic [7:0] op, input logic [3:0] n,
                                      input logic al);
        case (op)
            OP_WREN, OP_WRDI, OP_CE, OP_CE_ALT, OP_DPD: frame_ok = al && n == N_OP;
            OP_WRITE_STATUS: frame_ok = al && (n == N_WSR_ONE || n == N_WSR_TWO);
            OP_PP, OP_PP_ALT: frame_ok = al && n >= N_FAST_START;
            OP_SE, OP_BE32, OP_BE64: frame_ok = al && n == N_ADDR_END;
            default: frame_ok = 1'b0;
        endcase
    endfunction
endpackage

// *** design/frame_if.sv ***
`timescale 1ns/1ps
interface frame_if;
    logic fall;
    logic start;
    logic stop;
    logic byte_ok;
    logic aligned;
    logic [7:0] rx_byte;
    logic [3:0] byte_cnt;
    modport rx (output fall, start, stop, byte_ok, aligned, rx_byte, byte_cnt);
    modport dec (input fall, start, stop, byte_ok, aligned, rx_byte, byte_cnt);
endinterface

// *** design/spi_frame_rx.sv ***
`timescale 1ns/1ps
module spi_frame_rx (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    // to decoder
    frame_if.rx fr
);
    logic cs_q_r;
    logic sclk_q_r;
    logic active_r;
    logic [6:0] sh_r;
    logic [2:0] bit_idx_r;
    logic start_c;
    logic rise_c;

    // cs_q resets low so a frame needs cs seen high first
    assign start_c = cs_q_r & ~cs_n_i;
    assign rise_c = sclk_i & ~sclk_q_r & active_r & ~cs_n_i;
    assign fr.aligned = (bit_idx_r == 3'h0);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_q_r <= 1'b0;
            sclk_q_r <= 1'b0;
            active_r <= 1'b0;
        end else begin
            cs_q_r <= cs_n_i;
            sclk_q_r <= sclk_i;
            active_r <= start_c | (active_r & ~cs_n_i);
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_r <= 7'h00;
            bit_idx_r <= 3'h0;
            fr.byte_cnt <= 4'h0;
            fr.rx_byte <= 8'h00;
        end else if (start_c) begin
            bit_idx_r <= 3'h0;
            fr.byte_cnt <= 4'h0;
        end else if (rise_c) begin
            sh_r <= {sh_r[5:0], si_i}; // RL1
            bit_idx_r <= bit_idx_r + 3'h1;
            if (bit_idx_r == 3'h7) begin
                fr.rx_byte <= {sh_r, si_i};
                if (fr.byte_cnt != 4'hf) begin
                    fr.byte_cnt <= fr.byte_cnt + 4'h1;
                end
            end
        end
    end

    // one-cycle event pulses, all registered
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fr.fall <= 1'b0;
            fr.start <= 1'b0;
            fr.stop <= 1'b0;
            fr.byte_ok <= 1'b0;
        end else begin
            fr.fall <= ~sclk_i & sclk_q_r & active_r & ~cs_n_i;
            fr.start <= start_c;
            fr.stop <= active_r & cs_n_i;
            fr.byte_ok <= rise_c & (bit_idx_r == 3'h7);
        end
    end

    property p_msb_first;
        @(posedge ref_clk_i) disable iff (rst_i)
        (rise_c && bit_idx_r == 3'h7) |=> (fr.byte_ok && fr.rx_byte[0] == $past(si_i));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("byte not formed msb first"); // RL1
endmodule

// *** design/page_buf.sv ***
`timescale 1ns/1ps
module page_buf (
    // clock
    input wire logic ref_clk_i,
    // write side
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // read side
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:255];

    // no reset: contents are only valid for the bytes counted in
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// *** design/spi_flash_decoder.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RL1: bits travel msb first, sampled rising
// RL2: every frame opens with one opcode byte
// RL3: output stops as soon as cs rises
// RL4: write-type frames need whole bytes at end
// RL5: partial program byte: nothing, latch kept
// RL6: 06 sets latch, 04 clears it
// RL7: reads take address; fast adds dummy
// RL8: 02 and f2 both program pages
// RL9: erases take address; chip erase none
// RL10: ab releases sleep; dummies give id
// RL11: 90 returns maker then part code
// RL12: 9f returns maker, high, low codes
// RL13: dual read: even bits, odd bits
// RL14: writes refused while latch is clear
// RL15: latch clears at reset and completion
// RL16: status read always served, repeating; the decoder ignores it in deep power down
// RL17: status write keeps bits 6,5,1,0
// RL18: status write needs 8 or 16 bits
// RL19: status write runs timed, busy shown
// RL20: no status write under hardware lock
// RL21: read streams with rising address
// RL22: read during busy cycle is rejected
// RL23: bit 0 busy, bit 1 latch
// RL24: lock bit plus low pin locks bits
// RL25: bits 4..2 are protect bits
// RL26: unknown opcode ignored until cs rises
module spi_flash_decoder
    import flash_cmd_pkg::*;
#(
    parameter int unsigned WSR_CYCLES = STATUS_WRITE_CYCLES,
    parameter logic [7:0] MAKER_CODE_BYTE = MAKER_CODE_DEF,
    parameter logic [7:0] PART_CODE_HIGH = PART_HIGH_DEF,
    parameter logic [7:0] PART_CODE_LOW = PART_LOW_DEF,
    parameter logic [7:0] LEGACY_PART_CODE = LEGACY_PART_DEF
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic dual_line_even_i,
    output logic dual_line_even_o,
    output logic dual_line_even_oe_o,
    output logic dual_line_odd_o,
    output logic dual_line_odd_oe_o,
    // array read port
    output logic [23:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    // array program and erase port
    output logic op_start_o,
    output array_op_t op_kind_o,
    output logic [23:0] op_addr_o,
    output logic [8:0] op_count_o,
    input wire logic [7:0] pbuf_raddr_i,
    output logic [7:0] pbuf_rdata_o,
    input wire logic array_busy_i,
    input wire logic array_done_i,
    // state
    output logic [7:0] status_o,
    output logic [2:0] block_protect_bits_o,
    output logic hardware_lock_mode_o,
    output logic deep_power_down_o
);
    localparam int WSR_W = $clog2(WSR_CYCLES + 1);

    frame_if fr ();

    dec_state_t state_r;
    logic [7:0] opcode_r;
    logic [23:0] addr_r;
    logic [7:0] wsr_data_r;
    logic write_enable_latch_r;
    logic status_lock_bit_r;
    logic [2:0] block_protect_bits_r;
    logic wsr_busy_r;
    logic [WSR_W-1:0] wsr_cnt_r;
    logic dpd_r;
    logic [7:0] tx_sh_r;
    logic [2:0] tx_cnt_r;
    logic [1:0] out_idx_r;
    logic [8:0] pp_n_r;
    logic write_in_progress_flag;
    logic dual;
    logic in_end;
    logic end_ok;
    logic wren_ev;
    logic wrdi_ev;
    logic write_go;
    logic wsr_go;
    logic arr_go;
    logic wsr_done;
    logic enter_out;
    logic load_c;
    logic pp_we;
    logic [7:0] next_byte;
    dec_state_t first_st;

    spi_frame_rx u_spi_frame_rx (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .si_i(dual_line_even_i),
        .fr(fr.rx)
    );

    page_buf u_page_buf (
        .ref_clk_i(ref_clk_i),
        .we_i(pp_we),
        .waddr_i(addr_r[7:0] + pp_n_r[7:0]),
        .wdata_i(fr.rx_byte),
        .raddr_i(pbuf_raddr_i),
        .rdata_o(pbuf_rdata_o)
    );

    assign write_in_progress_flag = wsr_busy_r | array_busy_i;
    assign hardware_lock_mode_o = status_lock_bit_r & ~wp_n_i; // RL24
    assign status_o = {status_lock_bit_r, 2'b00, block_protect_bits_r,
                       write_enable_latch_r, write_in_progress_flag}; // RL23
    assign block_protect_bits_o = block_protect_bits_r; // RL25
    assign deep_power_down_o = dpd_r;
    assign dual = (opcode_r == OP_DREAD);
    assign rd_addr_o = addr_r;

    // frame end decode: a frame that ends mid-byte never qualifies
    assign in_end = fr.stop && state_r == ST_IN;
    assign end_ok = in_end && frame_ok(opcode_r, fr.byte_cnt, fr.aligned); // RL4 RL5 RL18
    assign wren_ev = end_ok && opcode_r == OP_WREN; // RL6
    assign wrdi_ev = end_ok && opcode_r == OP_WRDI; // RL6
    assign write_go = end_ok && write_enable_latch_r && !write_in_progress_flag; // RL14
    assign wsr_go = write_go && opcode_r == OP_WRITE_STATUS && !hardware_lock_mode_o; // RL20
    assign arr_go = write_go && arr_kind(opcode_r) != ARR_NONE; // RL8 RL9
    assign wsr_done = wsr_busy_r && wsr_cnt_r == WSR_W'(1);
    assign enter_out = fr.byte_ok && (state_r == ST_OPCODE ? first_st == ST_OUT :
                       state_r == ST_IN && out_start(opcode_r) == fr.byte_cnt); // RL7
    assign load_c = fr.fall && state_r == ST_OUT && tx_cnt_r == 3'h0;
    assign pp_we = fr.byte_ok && state_r == ST_IN && arr_kind(opcode_r) == ARR_PROGRAM
                   && fr.byte_cnt >= N_FAST_START;
    // output enables drop combinationally with cs
    assign dual_line_odd_oe_o = state_r == ST_OUT && !cs_n_i; // RL3
    assign dual_line_even_oe_o = state_r == ST_OUT && !cs_n_i && dual; // RL13

    // opcode screening at the first byte
    always_comb begin
        first_st = ST_IN;
        if (dpd_r) begin
            first_st = (fr.rx_byte == OP_RDP_ID) ? ST_IN : ST_IGNORE;
        end else if (fr.rx_byte == OP_READ_STATUS) begin
            first_st = ST_OUT; // RL16
        end else if (out_start(fr.rx_byte) != N_NONE) begin
            // reads and id readouts are not decoded during a busy cycle
            first_st = write_in_progress_flag ? ST_IGNORE :
                       (out_start(fr.rx_byte) == N_OP ? ST_OUT : ST_IN); // RL22 RL12
        end else if (!frame_ok(fr.rx_byte, 4'h0, 1'b1) && arr_kind(fr.rx_byte) == ARR_NONE
                     && fr.rx_byte != OP_WREN && fr.rx_byte != OP_WRDI
                     && fr.rx_byte != OP_WRITE_STATUS && fr.rx_byte != OP_CE
                     && fr.rx_byte != OP_DPD) begin
            first_st = ST_IGNORE; // RL26
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_WAIT;
            opcode_r <= 8'h00;
        end else if (fr.stop) begin
            state_r <= ST_WAIT;
        end else if (fr.start) begin
            state_r <= ST_OPCODE; // RL2
        end else if (fr.byte_ok) begin
            unique case (state_r)
                ST_OPCODE: begin
                    opcode_r <= fr.rx_byte;
                    state_r <= first_st;
                end
                ST_IN: begin
                    if (enter_out) begin
                        state_r <= ST_OUT;
                    end
                end
                ST_WAIT, ST_OUT, ST_IGNORE: begin
                end
            endcase
        end
    end

    // address capture and read auto-increment
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_r <= 24'h000000;
            wsr_data_r <= 8'h00;
        end else if (fr.byte_ok && state_r == ST_IN) begin
            if (fr.byte_cnt <= N_ADDR_END) begin
                addr_r <= {addr_r[15:0], fr.rx_byte};
            end
            if (fr.byte_cnt == N_WSR_ONE) begin
                wsr_data_r <= fr.rx_byte;
            end
        end else if (load_c && out_start(opcode_r) >= N_ADDR_END && opcode_r != OP_MFID
                     && opcode_r != OP_RDP_ID) begin
            addr_r <= addr_r + 24'h000001; // RL21
        end
    end

    always_comb begin
        unique case (opcode_r)
            OP_READ_STATUS: next_byte = status_o; // RL16
            OP_JEDEC: next_byte = (out_idx_r == 2'h0) ? MAKER_CODE_BYTE :
                                  (out_idx_r == 2'h1) ? PART_CODE_HIGH : PART_CODE_LOW; // RL12
            OP_MFID: next_byte = out_idx_r[0] ? LEGACY_PART_CODE : MAKER_CODE_BYTE; // RL11
            OP_RDP_ID: next_byte = LEGACY_PART_CODE; // RL10
            default: next_byte = rd_data_i;
        endcase
    end

    // shifter: bytes load on the first falling edge, pairs in dual mode
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_sh_r <= 8'h00;
            tx_cnt_r <= 3'h0;
            out_idx_r <= 2'h0;
            dual_line_odd_o <= 1'b0;
            dual_line_even_o <= 1'b0;
        end else if (enter_out) begin
            tx_cnt_r <= 3'h0;
            out_idx_r <= (state_r == ST_IN && opcode_r == OP_MFID) ?
                         {1'b0, fr.rx_byte[0]} : 2'h0;
        end else if (fr.fall && state_r == ST_OUT) begin
            if (tx_cnt_r == 3'h0) begin
                dual_line_odd_o <= next_byte[7];
                dual_line_even_o <= next_byte[6]; // RL13
                tx_sh_r <= dual ? {next_byte[5:0], 2'b00} : {next_byte[6:0], 1'b0};
                if (opcode_r == OP_JEDEC) begin
                    out_idx_r <= (out_idx_r == 2'h2) ? 2'h0 : out_idx_r + 2'h1;
                end else begin
                    out_idx_r <= out_idx_r ^ 2'h1;
                end
            end else begin
                dual_line_odd_o <= tx_sh_r[7];
                dual_line_even_o <= tx_sh_r[6];
                tx_sh_r <= dual ? {tx_sh_r[5:0], 2'b00} : {tx_sh_r[6:0], 1'b0};
            end
            tx_cnt_r <= (tx_cnt_r == (dual ? 3'h3 : 3'h7)) ? 3'h0 : tx_cnt_r + 3'h1;
        end
    end

    // latch: a set arriving with a completion clear wins
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            write_enable_latch_r <= 1'b0; // RL15
        end else if (wren_ev) begin
            write_enable_latch_r <= 1'b1; // RL6
        end else if (wrdi_ev || wsr_done || array_done_i) begin
            write_enable_latch_r <= 1'b0; // RL15
        end
    end

    // status write: only lock and protect bits take new values
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_lock_bit_r <= 1'b0;
            block_protect_bits_r <= 3'h0;
        end else if (wsr_go) begin
            status_lock_bit_r <= wsr_data_r[S_LOCK]; // RL17
            block_protect_bits_r <= wsr_data_r[4:2]; // RL25
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wsr_busy_r <= 1'b0;
            wsr_cnt_r <= '0;
        end else if (wsr_go) begin
            wsr_busy_r <= 1'b1; // RL19
            wsr_cnt_r <= WSR_W'(WSR_CYCLES);
        end else if (wsr_busy_r) begin
            wsr_cnt_r <= wsr_cnt_r - WSR_W'(1);
            wsr_busy_r <= !wsr_done;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dpd_r <= 1'b0;
        end else if (end_ok && opcode_r == OP_DPD && !write_in_progress_flag) begin
            dpd_r <= 1'b1;
        end else if (fr.stop && opcode_r == OP_RDP_ID
                     && (state_r == ST_IN || state_r == ST_OUT)) begin
            dpd_r <= 1'b0; // RL10
        end
    end

    // page data: count saturates at 256, later bytes all overwrite the start byte's slot, wrapping inside the page
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pp_n_r <= 9'h000;
            op_start_o <= 1'b0;
            op_kind_o <= ARR_NONE;
            op_addr_o <= 24'h000000;
            op_count_o <= 9'h000;
        end else begin
            op_start_o <= arr_go; // RL14
            if (fr.start) begin
                pp_n_r <= 9'h000;
            end else if (pp_we) begin
                pp_n_r <= (pp_n_r == PAGE_BYTES) ? PAGE_BYTES : pp_n_r + 9'h001;
            end
            if (arr_go) begin
                op_kind_o <= arr_kind(opcode_r);
                op_addr_o <= addr_r;
                op_count_o <= pp_n_r;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_wren_sets;
        (fr.stop && state_r == ST_IN && opcode_r == OP_WREN && fr.byte_cnt == N_OP
         && fr.aligned) |=> status_o[S_WRITE_EN];
    endproperty
    a_wren_sets: assert property (p_wren_sets) else $error("write enable lost"); // RL6

    property p_misaligned;
        (fr.stop && !fr.aligned && !write_enable_latch_r) |=> !status_o[S_WRITE_EN];
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("partial byte acted on"); // RL4

    property p_cs_ends_out;
        fr.stop |-> ##1 (state_r == ST_WAIT && !dual_line_odd_oe_o);
    endproperty
    a_cs_ends_out: assert property (p_cs_ends_out) else $error("output after cs high"); // RL3

    property p_needs_latch;
        $rose(op_start_o) |-> $past(write_enable_latch_r) && $past(fr.stop);
    endproperty
    a_needs_latch: assert property (p_needs_latch) else $error("write without latch"); // RL14

    property p_done_clears;
        (array_done_i && !wren_ev) |=> !write_enable_latch_r;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept after op"); // RL15

    property p_wsr_cycle;
        wsr_go |=> status_o[S_BUSY] && wsr_cnt_r == WSR_W'(WSR_CYCLES)
                   && status_o[6:5] == 2'b00 && status_o[S_WRITE_EN];
    endproperty
    a_wsr_cycle: assert property (p_wsr_cycle) else $error("status write cycle wrong"); // RL19

    property p_wsr_end;
        (wsr_done && !wren_ev) |=> !wsr_busy_r && !status_o[S_WRITE_EN];
    endproperty
    a_wsr_end: assert property (p_wsr_end) else $error("status write did not end"); // RL15

    property p_hw_lock;
        hardware_lock_mode_o |=> $stable(status_lock_bit_r) && $stable(block_protect_bits_o);
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("locked bits changed"); // RL20

    property p_read_busy;
        (fr.byte_ok && state_r == ST_OPCODE && fr.rx_byte == OP_READ && status_o[S_BUSY])
        |=> state_r == ST_IGNORE;
    endproperty
    a_read_busy: assert property (p_read_busy) else $error("read taken while busy"); // RL22

    property p_busy_bit;
        array_busy_i |-> status_o[S_BUSY];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit clear"); // RL23

    property p_ignore;
        (state_r == ST_IGNORE && fr.stop && !wsr_busy_r && !array_done_i)
        |=> $stable(write_enable_latch_r) && $stable(dpd_r) && !op_start_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored frame had effect"); // RL26

    c_status_read: cover property (load_c && opcode_r == OP_READ_STATUS);
    c_dual_read: cover property (load_c && dual);
    c_wsr: cover property (wsr_go);
    c_program: cover property (arr_go && arr_kind(opcode_r) == ARR_PROGRAM);
endmodule

// *** tb/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input wire logic ref_clk_i,
    // serial pins
    input wire logic so_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    // sclk idles low between frames
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        @(posedge ref_clk_i) cs_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk_i) sclk_o <= 1'b0;
            si_o <= tx[i];
            // wait past the 2-cycle output delay
            repeat (4) @(posedge ref_clk_i);
            rx = {rx[62:0], so_i};
            sclk_o <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
        end
        @(posedge ref_clk_i) sclk_o <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (6) @(posedge ref_clk_i);
    endtask
endmodule

// *** tb/spi_flash_instruction_decoder_tb.sv ***
`timescale 1ns/1ps
module spi_flash_instruction_decoder_tb;
    import flash_cmd_pkg::*;
    localparam int WSR = 20;
    // id values arbitrary
    localparam logic [7:0] MK = 8'h2d;
    localparam logic [7:0] HI = 8'h71;
    localparam logic [7:0] LO = 8'h0c;
    localparam logic [7:0] LG = 8'h4b;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic array_busy_i = 1'b0;
    logic array_done_i = 1'b0;
    logic [7:0] pbuf_raddr_i = 8'h00;
    logic sclk_i, cs_n_i, dual_line_even_i, dual_line_even_o, dual_line_even_oe_o;
    logic dual_line_odd_o, dual_line_odd_oe_o, op_start_o, hardware_lock_mode_o;
    logic deep_power_down_o;
    logic [23:0] rd_addr_o, op_addr_o;
    logic [8:0] op_count_o;
    logic [7:0] rd_data_i, pbuf_rdata_o, status_o;
    logic [2:0] block_protect_bits_o;
    array_op_t op_kind_o;
    logic [63:0] rx;
    int err_total = 0;
    int n_compared = 0;
    int starts = 0;
    logic [7:0] ev = 8'h00;
    assign rd_data_i = rd_addr_o[7:0] ^ 8'h5a;
    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (op_start_o === 1'b1) starts <= starts + 1;
    // even line gathered at each rise while driven
    always @(posedge sclk_i) if (dual_line_even_oe_o === 1'b1) ev <= {ev[6:0], dual_line_even_o};
    spi_flash_decoder #(.WSR_CYCLES(WSR), .MAKER_CODE_BYTE(MK), .PART_CODE_HIGH(HI),
        .PART_CODE_LOW(LO), .LEGACY_PART_CODE(LG)) u_spi_flash_decoder (.*);
    // no pull on the data line: a released line reads inverted
    spi_host_model u_spi_host_model (.ref_clk_i(ref_clk_i),
        .so_i(dual_line_odd_oe_o ? dual_line_odd_o : ~dual_line_odd_o),
        .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(dual_line_even_i));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tx(input logic [63:0] d, input int n);
        u_spi_host_model.frame(d, n, rx);
        #1;
    endtask
    task automatic done_pulse;
        @(posedge ref_clk_i) array_done_i <= 1'b1;
        @(posedge ref_clk_i) array_done_i <= 1'b0;
        #1;
    endtask
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic s_latch;
        tx(8'h06, 8);
        cmp(status_o, 8'h02);
        tx(8'h77, 8);
        cmp(status_o, 8'h02);
        tx(8'h04, 8);
        cmp(status_o, 8'h00);
        tx(9'h00c, 9);
        cmp(status_o, 8'h00);
    endtask
    // host sets the latch before the 02 frames; the f2 frame goes with it clear
    task automatic s_prog;
        tx(8'h06, 8);
        tx(40'h02010203a5, 40);
        cmp(starts, 1);
        cmp(op_kind_o, ARR_PROGRAM);
        cmp(op_addr_o, 24'h010203);
        cmp(op_count_o, 9'h001);
        @(posedge ref_clk_i) pbuf_raddr_i <= 8'h03;
        repeat (2) @(posedge ref_clk_i);
        #1 cmp(pbuf_rdata_o, 8'ha5);
        done_pulse;
        cmp(status_o, 8'h00);
        tx(40'hf2010203a5, 40);
        cmp(starts, 1);
        tx(8'h06, 8);
        tx(36'h02010203a, 36);
        cmp(starts, 1);
        cmp(status_o, 8'h02);
        tx(8'h60, 8);
        cmp(op_kind_o, ARR_CHIP);
        cmp(starts, 2);
        done_pulse;
    endtask
    task automatic s_read;
        tx({8'h03, 24'h0000fe, 16'h0}, 48);
        cmp(rx[15:0], 16'ha4a5);
        @(posedge ref_clk_i) array_busy_i <= 1'b1;
        tx(16'h0500, 16);
        cmp(rx[7:0], 8'h01);
        tx({8'h03, 24'h000040, 8'h0}, 40);
        cmp(rd_addr_o, 24'h000101);
        @(posedge ref_clk_i) array_busy_i <= 1'b0;
        tx({8'h0b, 24'h000010, 16'h0}, 48);
        cmp(rx[7:0], 8'h4a);
        tx({8'h3b, 24'h000010, 16'h0}, 48);
        cmp({rx[7:0], ev}, 16'h3389);
    endtask
    task automatic s_wsr;
        tx(8'h06, 8);
        tx(20'h01fc0, 20);
        cmp(status_o, 8'h02);
        tx(16'h01fc, 16);
        cmp(status_o[0], 1'b1);
        repeat (WSR) @(posedge ref_clk_i);
        #1 cmp(status_o, 8'h9c);
        cmp(block_protect_bits_o, 3'h7);
        @(posedge ref_clk_i) wp_n_i <= 1'b0;
        tx(8'h06, 8);
        tx(16'h0100, 16);
        repeat (WSR) @(posedge ref_clk_i);
        #1 cmp(status_o, 8'h9e);
        cmp(hardware_lock_mode_o, 1'b1);
    endtask
    task automatic s_ids;
        tx(32'h9f000000, 32);
        cmp(rx[23:0], {MK, HI, LO});
        tx({8'h90, 24'h0, 16'h0}, 48);
        cmp(rx[15:0], {MK, LG});
        tx({8'hab, 24'h0, 8'h0}, 40);
        cmp(rx[7:0], LG);
        tx(24'h050000, 24);
        cmp(rx[15:0], 16'h9e9e);
        tx(8'hb9, 8);
        cmp(deep_power_down_o, 1'b1);
        tx(8'hab, 8);
        cmp(deep_power_down_o, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        s_latch;
        s_prog;
        s_read;
        s_wsr;
        s_ids;
        final_report;
    end
    initial begin
        #3000000;
        err_total++;
        final_report;
    end
endmodule
